// ---- verilog/odc_pkg.sv ----
// Shared constants and types of the opcode decoder, condition evaluator and
// add-with-carry unit.
// Assumes one core clock domain and byte-wide flags held inside the block.
package odc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam int        APB_AW       = 8;
  localparam logic [7:0] OFS_OPCODE   = 8'h00;
  localparam logic [7:0] OFS_FLAGS    = 8'h04;
  localparam logic [7:0] OFS_DECODE   = 8'h08;
  localparam logic [7:0] OFS_OPERANDS = 8'h0C;
  localparam logic [7:0] OFS_RESULT   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;

  // ==========================================================================
  // Reset values and the flags mask
  localparam logic [7:0]  OPCODE_RST = 8'hFF;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  FLAGS_MASK = 8'hFC;
  localparam logic [15:0] WORD16_RST = 16'h0000;

  // ==========================================================================
  // Flag bit positions inside the flags byte
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;

  // ==========================================================================
  // Field positions in the decode, status, operand and result words
  localparam int DEC_KIND_LSB  = 0;
  localparam int DEC_REG_LSB   = 8;
  localparam int DEC_COND_LSB  = 12;
  localparam int DEC_TAKEN_BIT = 16;
  localparam int DEC_SRCF_BIT  = 17;
  localparam int DEC_BYTES_LSB = 18;
  localparam int DEC_CYC_LSB   = 20;
  localparam int STS_BUSY_BIT  = 0;
  localparam int STS_REFUSE_BIT = 1;
  localparam int RES_SRC_LSB   = 8;

  // ==========================================================================
  // Lower-nibble columns of the upper opcode map
  localparam logic [3:0] LN_LOAD   = 4'h8;
  localparam logic [3:0] LN_STORE  = 4'h9;
  localparam logic [3:0] LN_DECBR  = 4'hA;
  localparam logic [3:0] LN_REL    = 4'hB;
  localparam logic [3:0] LN_IMM    = 4'hC;
  localparam logic [3:0] LN_DIRECT = 4'hD;
  localparam logic [3:0] LN_INC    = 4'hE;
  localparam logic [3:0] LN_EXT    = 4'hF;

  // ==========================================================================
  // Add-with-carry encodings and timing
  localparam logic [7:0] OPC_ADC_R_R    = 8'h12;
  localparam logic [7:0] OPC_ADC_R_IR   = 8'h13;
  localparam logic [7:0] OPC_ADC_RG_RG  = 8'h14;
  localparam logic [7:0] OPC_ADC_RG_IRG = 8'h15;
  localparam logic [7:0] OPC_ADC_RG_IMM = 8'h16;
  localparam logic [2:0] ADC_CYC_SHORT  = 3'h4;
  localparam logic [2:0] ADC_CYC_LONG   = 3'h6;
  localparam logic [1:0] ADC_BYTES_TWO  = 2'h2;
  localparam logic [1:0] ADC_BYTES_THREE = 2'h3;

  // ==========================================================================
  // Condition field codes
  localparam logic [3:0] COND_FALSE       = 4'h0;
  localparam logic [3:0] COND_TRUE        = 4'h8;
  localparam logic [3:0] UNSIGNED_LT_COND = 4'h7;
  localparam logic [3:0] UNSIGNED_GE_COND = 4'hF;
  localparam logic [3:0] EQUAL_COND       = 4'h6;
  localparam logic [3:0] NOT_EQUAL_COND   = 4'hE;
  localparam logic [3:0] CARRY_COND       = UNSIGNED_LT_COND;
  localparam logic [3:0] NO_CARRY_COND    = UNSIGNED_GE_COND;
  localparam logic [3:0] ZERO_COND        = EQUAL_COND;
  localparam logic [3:0] NONZERO_COND     = NOT_EQUAL_COND;
  localparam logic [3:0] PLUS_COND        = 4'hD;
  localparam logic [3:0] MINUS_COND       = 4'h5;
  localparam logic [3:0] OVERFLOW_COND    = 4'h4;
  localparam logic [3:0] NO_OVERFLOW_COND = 4'hC;
  localparam logic [3:0] SIGNED_GE_COND   = 4'h9;
  localparam logic [3:0] SIGNED_LT_COND   = 4'h1;
  localparam logic [3:0] SIGNED_GT_COND   = 4'hA;
  localparam logic [3:0] SIGNED_LE_COND   = 4'h2;
  localparam logic [3:0] UNSIGNED_GT_COND = 4'hB;
  localparam logic [3:0] UNSIGNED_LE_COND = 4'h3;

  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    OTHER_OP, LOAD_OP, STORE_OP, DEC_BRANCH_NONZERO, REL_JUMP, IMM_LOAD_OP,
    DIRECT_JUMP, INC_OP, THREAD_NEXT, THREAD_ENTER, THREAD_EXIT,
    WAIT_INTERRUPT_OP, BANK_ZERO_SELECT, BANK_ONE_SELECT, IDLE_OP, STOP_OP,
    IRQ_DISABLE_OP, IRQ_ENABLE_OP, SUB_RETURN_OP, IRQ_RETURN_OP,
    CARRY_CLEAR_OP, CARRY_SET_OP, CARRY_INVERT_OP, NO_OPERATION,
    ADC_R_R, ADC_R_IR, ADC_RG_RG, ADC_RG_IRG, ADC_RG_IMM
  } odc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } odc_state_t;

  // Lower nibble F, indexed by the upper nibble
  localparam odc_op_t EXT_COLUMN_OPS [16] = '{
    THREAD_NEXT, THREAD_ENTER, THREAD_EXIT, WAIT_INTERRUPT_OP,
    BANK_ZERO_SELECT, BANK_ONE_SELECT, IDLE_OP, STOP_OP,
    IRQ_DISABLE_OP, IRQ_ENABLE_OP, SUB_RETURN_OP, IRQ_RETURN_OP,
    CARRY_CLEAR_OP, CARRY_SET_OP, CARRY_INVERT_OP, NO_OPERATION
  };

endpackage

// ---- verilog/odc_cond_eval.sv ----
// Condition-field evaluator for conditional jumps.
// Assumes the flag inputs are the current flag register bits.
`timescale 1ns/10ps

module odc_cond_eval
  import odc_pkg::*;
(
  input  logic [3:0] cond_field,
  input  logic       flag_c,
  input  logic       flag_z,
  input  logic       flag_s,
  input  logic       flag_v,
  output logic       cond_true
);

  logic sv_diff;

  // ==========================================================================
  // Evaluation
  // only C Z S V
  assign sv_diff = flag_s ^ flag_v;

  always_comb begin
    unique case (cond_field)
      COND_FALSE:       cond_true = 1'b0;
      COND_TRUE:        cond_true = 1'b1;
      CARRY_COND:       cond_true = flag_c;
      NO_CARRY_COND:    cond_true = ~flag_c;
      ZERO_COND:        cond_true = flag_z;
      NONZERO_COND:     cond_true = ~flag_z;
      PLUS_COND:        cond_true = ~flag_s;
      MINUS_COND:       cond_true = flag_s;
      OVERFLOW_COND:    cond_true = flag_v;
      NO_OVERFLOW_COND: cond_true = ~flag_v;
      SIGNED_GE_COND:   cond_true = ~sv_diff;
      SIGNED_LT_COND:   cond_true = sv_diff;
      SIGNED_GT_COND:   cond_true = ~(flag_z | sv_diff);
      SIGNED_LE_COND:   cond_true = flag_z | sv_diff;
      UNSIGNED_GT_COND: cond_true = ~flag_c & ~flag_z;
      UNSIGNED_LE_COND: cond_true = flag_c | flag_z;
    endcase
  end

endmodule

// ---- verilog/odc_decoder_top.sv ----
// Upper-half opcode decoder with condition evaluation and an add-with-carry
// unit, reached by software over APB.
// Assumes an APB master on sys_clk; pslverr answers unmapped addresses.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - jumps carry four-bit condition field
// - conditions use only C Z S V
// - 0000 never true, 1000 always
// - 0111 carry set, 1111 carry clear
// - 0110 zero set, 1110 zero clear
// - 0100 overflow set, 1100 clear
// - 1001/0001 test sign xor overflow
// - 1010/0010 test zero or sign-xor-overflow
// - 1011 neither carry nor zero, 0011 either
// - columns 8 to E decode fixed kinds
// - column F threaded ops and returns
// - column F control and carry ops
// - add-with-carry: dst plus src plus carry
// - carry, zero, sign from the result
// - overflow on same-sign operands, sign flip
// - decimal flag cleared, half-carry from nibble
// - 12h four cycles, 13h six
// - 14h-16h six cycles, 14h/15h source byte first
module odc_decoder_top
  import odc_pkg::*;
(
  input  logic              sys_clk,
  input  logic              rstn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [APB_AW-1:0] paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic [4:0]        op_kind,
  output logic [3:0]        reg_num,
  output logic [3:0]        cond_field,
  output logic              jump_taken,
  output logic [1:0]        instr_bytes,
  output logic [2:0]        instr_cycles,
  output logic              adc_busy,
  output logic [7:0]        flags_out
);

  // ==========================================================================
  // Functions
  function automatic odc_op_t decode_op(input logic [7:0] opc);
    odc_op_t kind;
    kind = OTHER_OP;
    unique case (opc[3:0])
      LN_LOAD:   kind = LOAD_OP;
      LN_STORE:  kind = STORE_OP;
      LN_DECBR:  kind = DEC_BRANCH_NONZERO;
      LN_REL:    kind = REL_JUMP;
      LN_IMM:    kind = IMM_LOAD_OP;
      LN_DIRECT: kind = DIRECT_JUMP;
      LN_INC:    kind = INC_OP;
      LN_EXT:    kind = EXT_COLUMN_OPS[opc[7:4]];
      default: begin
        // Lower half of the map is decoded elsewhere, except add-with-carry
        unique case (opc)
          OPC_ADC_R_R:    kind = ADC_R_R;
          OPC_ADC_R_IR:   kind = ADC_R_IR;
          OPC_ADC_RG_RG:  kind = ADC_RG_RG;
          OPC_ADC_RG_IRG: kind = ADC_RG_IRG;
          OPC_ADC_RG_IMM: kind = ADC_RG_IMM;
          default:        kind = OTHER_OP;
        endcase
      end
    endcase
    return kind;
  endfunction

  function automatic logic is_adc(input odc_op_t kind);
    return (kind == ADC_R_R) || (kind == ADC_R_IR) || (kind == ADC_RG_RG) ||
           (kind == ADC_RG_IRG) || (kind == ADC_RG_IMM);
  endfunction

  function automatic logic [2:0] adc_cycles(input odc_op_t kind);
    return (kind == ADC_R_R) ? ADC_CYC_SHORT : ADC_CYC_LONG;
  endfunction

  function automatic logic [1:0] adc_bytes(input odc_op_t kind);
    return ((kind == ADC_R_R) || (kind == ADC_R_IR)) ? ADC_BYTES_TWO
                                                     : ADC_BYTES_THREE;
  endfunction

  function automatic logic src_first(input odc_op_t kind);
    return (kind == ADC_RG_RG) || (kind == ADC_RG_IRG);
  endfunction

  function automatic logic addr_hit(input logic [APB_AW-1:0] addr);
    return (addr == OFS_OPCODE) || (addr == OFS_FLAGS) ||
           (addr == OFS_DECODE) || (addr == OFS_OPERANDS) ||
           (addr == OFS_RESULT) || (addr == OFS_STATUS);
  endfunction

  // ==========================================================================
  // Declarations
  odc_state_t  state_reg;
  odc_op_t     kind_reg;
  odc_op_t     wr_kind;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;
  logic        commit;
  logic        wr_commit;
  logic [7:0]  opcode_reg;
  logic [7:0]  flags_reg;
  logic [3:0]  reg_num_reg;
  logic [3:0]  cond_field_reg;
  logic        jump_taken_reg;
  logic [1:0]  bytes_reg;
  logic [2:0]  cycles_reg;
  logic        srcf_reg;
  logic [7:0]  dst_reg;
  logic [7:0]  src_reg;
  logic [7:0]  result_reg;
  logic [7:0]  src_echo_reg;
  logic [2:0]  cnt_reg;
  logic        refuse_reg;
  logic        start_adc;
  logic        finish_adc;
  logic        cond_true;
  logic [8:0]  sum9;
  logic [4:0]  sum_low;
  logic        adc_v;
  logic [7:0]  adc_flags;

  assign commit    = psel & penable & pready_reg;
  assign wr_commit = commit & pwrite;
  assign wr_kind   = decode_op(pwdata[7:0]);

  // ==========================================================================
  // APB slave: one wait state, then pready with registered data
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        pslverr_reg <= ~addr_hit(paddr);
        prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      OFS_OPCODE: rdata_next[7:0] = opcode_reg;
      OFS_FLAGS:  rdata_next[7:0] = flags_reg;
      OFS_DECODE: begin
        rdata_next[DEC_KIND_LSB +: 5]  = kind_reg;
        rdata_next[DEC_REG_LSB +: 4]   = reg_num_reg;
        rdata_next[DEC_COND_LSB +: 4]  = cond_field_reg;
        rdata_next[DEC_TAKEN_BIT]      = jump_taken_reg;
        rdata_next[DEC_SRCF_BIT]       = srcf_reg;
        rdata_next[DEC_BYTES_LSB +: 2] = bytes_reg;
        rdata_next[DEC_CYC_LSB +: 3]   = cycles_reg;
      end
      OFS_OPERANDS: begin
        rdata_next[7:0]               = dst_reg;
        rdata_next[RES_SRC_LSB +: 8]  = src_reg;
      end
      OFS_RESULT: begin
        rdata_next[7:0]               = result_reg;
        rdata_next[RES_SRC_LSB +: 8]  = src_echo_reg;
      end
      OFS_STATUS: begin
        rdata_next[STS_BUSY_BIT]   = (state_reg == ST_EXEC);
        rdata_next[STS_REFUSE_BIT] = refuse_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Opcode register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opcode_reg <= OPCODE_RST;
    end else if (wr_commit && (paddr == OFS_OPCODE)) begin
      opcode_reg <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Decode outputs, refreshed every cycle from the held opcode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      kind_reg       <= NO_OPERATION;
      reg_num_reg    <= 4'h0;
      cond_field_reg <= COND_FALSE;
      jump_taken_reg <= 1'b0;
      bytes_reg      <= 2'h0;
      cycles_reg     <= 3'h0;
      srcf_reg       <= 1'b0;
    end else begin
      kind_reg <= decode_op(opcode_reg);
      reg_num_reg <= ((opcode_reg[3:0] >= LN_LOAD) && (opcode_reg[3:0] <= LN_INC))
                     ? opcode_reg[7:4] : 4'h0;
      cond_field_reg <= ((opcode_reg[3:0] == LN_REL) || (opcode_reg[3:0] == LN_DIRECT))
                        ? opcode_reg[7:4] : COND_FALSE;
      jump_taken_reg <= ((opcode_reg[3:0] == LN_REL) || (opcode_reg[3:0] == LN_DIRECT))
                        & cond_true;
      bytes_reg  <= is_adc(decode_op(opcode_reg)) ? adc_bytes(decode_op(opcode_reg))
                                                  : 2'h0;
      cycles_reg <= is_adc(decode_op(opcode_reg)) ? adc_cycles(decode_op(opcode_reg))
                                                  : 3'h0;
      srcf_reg   <= src_first(decode_op(opcode_reg));
    end
  end

  odc_cond_eval u_cond_eval (
    .cond_field (opcode_reg[7:4]),
    .flag_c     (flags_reg[FLG_C]),
    .flag_z     (flags_reg[FLG_Z]),
    .flag_s     (flags_reg[FLG_S]),
    .flag_v     (flags_reg[FLG_V]),
    .cond_true  (cond_true)
  );

  // ==========================================================================
  // Add-with-carry arithmetic
  // dst plus src plus carry
  assign sum9    = {1'b0, dst_reg} + {1'b0, src_reg} + {8'h00, flags_reg[FLG_C]};
  assign sum_low = {1'b0, dst_reg[3:0]} + {1'b0, src_reg[3:0]} +
                   {4'h0, flags_reg[FLG_C]};
  assign adc_v   = (dst_reg[7] == src_reg[7]) && (sum9[7] != dst_reg[7]);

  always_comb begin
    adc_flags        = flags_reg;
    adc_flags[FLG_C] = sum9[8];
    adc_flags[FLG_Z] = (sum9[7:0] == 8'h00);
    adc_flags[FLG_S] = sum9[7];
    adc_flags[FLG_V] = adc_v;
    adc_flags[FLG_D] = 1'b0;
    adc_flags[FLG_H] = sum_low[4];
  end

  // Operands can only start a run while idle and an add-with-carry is held
  assign start_adc  = wr_commit && (paddr == OFS_OPERANDS) &&
                      (state_reg == ST_IDLE) && is_adc(kind_reg);
  assign finish_adc = (state_reg == ST_EXEC) && (cnt_reg == 3'h0);

  // ==========================================================================
  // Execution sequencer, counts out the form's cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_adc) begin
            state_reg <= ST_EXEC;
            cnt_reg   <= cycles_reg - 3'h1;
          end
        end
        ST_EXEC: begin
          if (cnt_reg == 3'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cnt_reg   <= 3'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Operand latch; byte order follows the instruction form
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dst_reg <= 8'h00;
      src_reg <= 8'h00;
    end else if (start_adc) begin
      if (srcf_reg) begin
        src_reg <= pwdata[7:0];
        dst_reg <= pwdata[RES_SRC_LSB +: 8];
      end else begin
        dst_reg <= pwdata[7:0];
        src_reg <= pwdata[RES_SRC_LSB +: 8];
      end
    end
  end

  // ==========================================================================
  // Result; the source is only echoed, never changed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg   <= 8'h00;
      src_echo_reg <= 8'h00;
    end else if (finish_adc) begin
      result_reg   <= sum9[7:0];
      src_echo_reg <= src_reg;
    end
  end

  // ==========================================================================
  // Flags; completion beats a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= FLAGS_RST;
    end else if (finish_adc) begin
      flags_reg <= adc_flags & FLAGS_MASK;
    end else if (wr_commit && (paddr == OFS_FLAGS)) begin
      flags_reg <= pwdata[7:0] & FLAGS_MASK;
    end else if (wr_commit && (paddr == OFS_OPCODE)) begin
      unique case (wr_kind)
        CARRY_CLEAR_OP:  flags_reg[FLG_C] <= 1'b0;
        CARRY_SET_OP:    flags_reg[FLG_C] <= 1'b1;
        CARRY_INVERT_OP: flags_reg[FLG_C] <= ~flags_reg[FLG_C];
        default:         flags_reg <= flags_reg;
      endcase
    end
  end

  // ==========================================================================
  // Refused-start flag: set on an operand write that cannot start, write 1 to
  // clear; a new refusal in the clearing cycle keeps it set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refuse_reg <= 1'b0;
    end else if (wr_commit && (paddr == OFS_OPERANDS) && !start_adc) begin
      refuse_reg <= 1'b1;
    end else if (wr_commit && (paddr == OFS_STATUS) && pwdata[STS_REFUSE_BIT]) begin
      refuse_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign op_kind      = kind_reg;
  assign reg_num      = reg_num_reg;
  assign cond_field   = cond_field_reg;
  assign jump_taken   = jump_taken_reg;
  assign instr_bytes  = bytes_reg;
  assign instr_cycles = cycles_reg;
  assign flags_out    = flags_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adc_busy <= 1'b0;
    end else begin
      adc_busy <= start_adc | ((state_reg == ST_EXEC) & ~finish_adc);
    end
  end

endmodule

// ---- tb/odc_chk.sv ----
// Checker of the decoder top: APB answer timing, decode fields, ADC runs.
// Assumes it is bound to odc_decoder_top and sees only that module's ports.
`timescale 1ns/10ps
module odc_chk
  import odc_pkg::*;
(
  input logic        sys_clk,
  input logic        rstn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [4:0]  op_kind,
  input logic [3:0]  reg_num,
  input logic [3:0]  cond_field,
  input logic        jump_taken,
  input logic [1:0]  instr_bytes,
  input logic [2:0]  instr_cycles,
  input logic        adc_busy,
  input logic [7:0]  flags_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Add-with-carry run lengths, busy counted from its rise
  sequence busy4_s; adc_busy [*4] ##1 !adc_busy; endsequence
  sequence busy6_s; adc_busy [*6] ##1 !adc_busy; endsequence
  ack_one_a: assert property (pready |=> !pready) else $error("pready too long");
  ack_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  err_ack_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  jump_col_a: assert property (jump_taken |-> op_kind inside {REL_JUMP, DIRECT_JUMP})
    else $error("jump outside jump columns");
  never_jump_a: assert property (cond_field == COND_FALSE |-> !jump_taken)
    else $error("false condition taken");
  cond_col_a: assert property (cond_field != 4'h0 |->
    op_kind inside {REL_JUMP, DIRECT_JUMP}) else $error("condition field outside jumps");
  short_run_a: assert property ($rose(adc_busy) && op_kind == ADC_R_R |-> busy4_s)
    else $error("short run length wrong");
  long_run_a: assert property ($rose(adc_busy) && op_kind != ADC_R_R |-> busy6_s)
    else $error("long run length wrong");
  dec_clear_a: assert property ($fell(adc_busy) |-> !flags_out[FLG_D])
    else $error("decimal flag left set");
  imm_enc_a: assert property (op_kind == ADC_RG_IMM |->
    instr_bytes == ADC_BYTES_THREE && instr_cycles == ADC_CYC_LONG) else $error("imm form");
endmodule

bind odc_decoder_top odc_chk chk_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .op_kind(op_kind), .reg_num(reg_num),
  .cond_field(cond_field), .jump_taken(jump_taken), .instr_bytes(instr_bytes),
  .instr_cycles(instr_cycles), .adc_busy(adc_busy), .flags_out(flags_out));

// ---- tb/testbench.sv ----
// Self-checking bench of the decoder top, driven over APB only.
// Assumes the odc_pkg register map and one wait state per transfer.
`timescale 1ns/10ps
module testbench
  import odc_pkg::*;
;
  logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, flags_out;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
  logic        pready, pslverr, jump_taken, adc_busy, rd_err;
  logic [4:0]  op_kind;
  logic [3:0]  reg_num, cond_field;
  logic [1:0]  instr_bytes;
  logic [2:0]  instr_cycles;
  int          mismatches = 0, cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  odc_decoder_top dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_kind(op_kind), .reg_num(reg_num), .cond_field(cond_field),
    .jump_taken(jump_taken), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles),
    .adc_busy(adc_busy), .flags_out(flags_out));
  // ==========================================================================
  // Shared tasks
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    i = 0;
    do begin @(posedge sys_clk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin mismatches++; close_out(); end
    rd_data = prdata; rd_err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  function automatic logic exp_cond(logic [3:0] cc, logic c, logic z, logic s, logic v);
    logic r;
    case (cc[2:0])
      3'h0: r = 0;      3'h1: r = s ^ v;  3'h2: r = z | (s ^ v);  3'h3: r = c | z;
      3'h4: r = v;      3'h5: r = s;      3'h6: r = z;            default: r = c;
    endcase
    return r ^ cc[3];
  endfunction
  // ==========================================================================
  // Scenarios
  task automatic t_misc;
    chk(op_kind, NO_OPERATION);
    apb(0, 8'h40, 32'h0000_0000);
    chk(rd_err, 1'b1);
    chk(rd_data, 32'h0000_0000);
    // Operand write with no add-with-carry held is refused; write 1 clears it
    apb(1, OFS_OPERANDS, 32'h0000_0000);
    apb(0, OFS_STATUS, 32'h0000_0000);
    chk(rd_data[1:0], 2'b10);
    apb(1, OFS_STATUS, 32'h0000_0002);
    apb(0, OFS_STATUS, 32'h0000_0000);
    chk(rd_data[1:0], 2'b00);
  endtask
  task automatic t_cols;
    logic [4:0] x;
    for (int u = 0; u < 16; u++) for (int lo = 8; lo < 16; lo++) begin
      apb(1, OFS_OPCODE, {24'h00_0000, u[3:0], lo[3:0]});
      apb(0, OFS_DECODE, 32'h0000_0000);
      x = (lo == 15) ? 5'(8 + u) : 5'(lo - 7);
      chk(rd_data[4:0], x);
      chk(op_kind, x);
      chk(reg_num, (lo == 15) ? 4'h0 : u[3:0]);
      // Carry clear, set, invert in that order: only the set leaves C high
      if (lo == 15 && u > 11 && u < 15) chk(flags_out[FLG_C], u == 13);
    end
  endtask
  task automatic t_cond;
    logic e;
    for (int f = 0; f < 16; f++) begin
      // Decimal and half-carry preset opposite to sign and overflow
      apb(1, OFS_FLAGS, {24'h00_0000, f[3:0], ~f[1:0], 2'b00});
      for (int k = 0; k < 32; k++) begin
        apb(1, OFS_OPCODE, {24'h00_0000, k[3:0], k[4] ? LN_DIRECT : LN_REL});
        apb(0, OFS_DECODE, 32'h0000_0000);
        e = exp_cond(k[3:0], f[3], f[2], f[1], f[0]);
        chk(rd_data[DEC_TAKEN_BIT], e);
        chk(jump_taken, e);
        chk(cond_field, k[3:0]);
      end
    end
  endtask
  task automatic t_adc(input logic [7:0] op, a, b, input logic c);
    logic [7:0] d, s, r;
    logic [8:0] sum;
    logic       sf, v, h;
    logic [2:0] cyc;
    logic [1:0] nb;
    int         n;
    sf = (op == OPC_ADC_RG_RG || op == OPC_ADC_RG_IRG);
    d = sf ? b : a;
    s = sf ? a : b;
    sum = d + s + c;
    r = sum[7:0];
    v = (d[7] == s[7]) && (r[7] != d[7]);
    h = (d[3:0] + s[3:0] + c) > 15;
    apb(1, OFS_OPCODE, {24'h00_0000, op});
    apb(1, OFS_FLAGS, {24'h00_0000, c, 7'b000_1100});
    apb(1, OFS_OPERANDS, {16'h0000, b, a});
    n = 0;
    do begin @(posedge sys_clk); n++; end while (adc_busy === 1'b1 && n < 20);
    chk(n - 1, (op == OPC_ADC_R_R) ? 4 : 6);
    apb(0, OFS_RESULT, 32'h0000_0000);
    chk(rd_data[15:0], {s, r});
    apb(0, OFS_FLAGS, 32'h0000_0000);
    chk(rd_data[7:0], {sum[8], r == 8'h00, r[7], v, 1'b0, h, 2'b00});
    apb(0, OFS_DECODE, 32'h0000_0000);
    cyc = (op == OPC_ADC_R_R) ? 3'h4 : 3'h6;
    nb = (op < OPC_ADC_RG_RG) ? 2'h2 : 2'h3;
    chk(rd_data[22:17], {cyc, nb, sf});
    chk({instr_cycles, instr_bytes}, {cyc, nb});
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1;
    t_misc();
    t_cols();
    t_cond();
    t_adc(OPC_ADC_R_R, 8'h10, 8'h03, 1'b1);
    t_adc(OPC_ADC_R_IR, 8'h7F, 8'h00, 1'b1);
    t_adc(OPC_ADC_RG_RG, 8'h01, 8'hFF, 1'b0);
    t_adc(OPC_ADC_RG_IRG, 8'h80, 8'h80, 1'b1);
    t_adc(OPC_ADC_RG_IMM, 8'h0F, 8'h11, 1'b0);
    close_out();
  end
endmodule
